/* verif/mrc_user_model.sv */
/*
 * User-side model that drives the message request and management ports.
 * Assumes it is called just after a rising edge and that reset has already been released.
 */
`timescale 1ns/1ps
module mrc_user_model (
	input wire logic clock_in,
	input wire logic msi_sent_in,
	input wire logic msi_tlp_valid_in,
	input wire logic mgmt_done_in,
	input wire logic [31:0] mgmt_read_data_in,
	output logic [31:0] msi_int_out,
	output mrc_pkg::mrc_mgmt_req_t mgmt_out
);
	// Both ports start idle.
	initial
	begin
		msi_int_out = 32'h0000_0000;
		mgmt_out = '0;
	end
	////////////////////////////////////////
	// One management access: held until done, then released, with the stale fields scrambled.
	task automatic access(input logic wr, input logic [17:0] a, input logic [31:0] d, input logic [3:0] be,
		input logic ovr, output logic [31:0] rdata, output logic ok);
		ok = 1'b0;
		rdata = 32'h0000_0000;
		mgmt_out <= '{a, d, be, wr, !wr, ovr};
		for (int n = 0; n < 16 && !ok; n++)
		begin
			@(posedge clock_in);
			ok = mgmt_done_in;
			rdata = mgmt_read_data_in;
		end
		mgmt_out <= {~mgmt_out[56:3], 3'b000};
		@(posedge clock_in);
	endtask
	// One message request, held until accepted and then returned to zero.
	task automatic raise(input logic [31:0] v, output logic sent, output logic tlp);
		sent = 1'b0;
		msi_int_out <= v;
		for (int n = 0; n < 8 && !sent; n++)
		begin
			@(posedge clock_in);
			sent = msi_sent_in;
		end
		msi_int_out <= 32'h0000_0000;
		@(posedge clock_in);
		tlp = msi_tlp_valid_in;
		@(posedge clock_in);
	endtask
endmodule

/* verif/msi_request_and_cfg_port_tb_top.sv */
/*
 * Self-checking testbench for the message request and configuration port.
 * Assumes the user model above and the package constants for indices and masks.
 */
`timescale 1ns/1ps
module msi_request_and_cfg_port_tb_top;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [31:0] msi_int_in, rd_data, prev;
	mrc_pkg::mrc_mgmt_req_t mgmt_in;
	mrc_pkg::mrc_msi_tlp_t msi_tlp_out;
	logic msi_sent_out, msi_enable_out, msi_tlp_valid_out, mgmt_done_out, ok, sent, tlp;
	logic [2:0] msi_mmenable_out;
	logic [31:0] mgmt_read_data_out;
	int failures = 0;
	int n_checks = 0;
	// Clock at 125 MHz.
	always #4 clock_in = ~clock_in;
	// Device under test with a capable count below the enable count.
	mrc_msi_cfg #(.MSG_CAPABLE(3'h3), .ROOT_PORT(1'b0), .FUNC_COUNT(1)) u_dut (.clock_in(clock_in),
		.reset_n_in(reset_n_in), .msi_int_in(msi_int_in), .mgmt_in(mgmt_in), .msi_sent_out(msi_sent_out),
		.msi_enable_out(msi_enable_out), .msi_mmenable_out(msi_mmenable_out), .msi_tlp_valid_out(msi_tlp_valid_out),
		.msi_tlp_out(msi_tlp_out), .mgmt_read_data_out(mgmt_read_data_out), .mgmt_done_out(mgmt_done_out));
	// User application model on the far side.
	mrc_user_model u_user (.clock_in(clock_in), .msi_sent_in(msi_sent_out), .msi_tlp_valid_in(msi_tlp_valid_out),
		.mgmt_done_in(mgmt_done_out), .mgmt_read_data_in(mgmt_read_data_out), .msi_int_out(msi_int_in),
		.mgmt_out(mgmt_in));
	////////////////////////////////////////
	// Comparison, access helpers and verdict.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] be, input logic ovr);
		u_user.access(1'b1, a, d, be, ovr, rd_data, ok);
		check(ok, 1'b1);
	endtask
	task automatic rd(input logic [17:0] a, input logic [31:0] m, input logic [31:0] exp);
		u_user.access(1'b0, a, 32'h0000_0000, 4'h0, 1'b0, rd_data, ok);
		check(ok, 1'b1);
		check(rd_data & m, exp);
	endtask
	task automatic msi(input logic [31:0] v, input logic es, input logic [63:0] ea, input logic [31:0] ed,
		input logic e64);
		u_user.raise(v, sent, tlp);
		check(sent, es);
		check(tlp, es);
		if (es)
		begin
			check(msi_tlp_out.addr, ea);
			check(msi_tlp_out.data, ed);
			check(msi_tlp_out.is_64, e64);
		end
	endtask
	task automatic results;
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog against a hang.
	initial
	begin
		#100000;
		failures++;
		results();
	end
	// Test sequence.
	initial
	begin
		repeat (10) @(posedge clock_in);
		reset_n_in <= 1'b1;
		@(posedge clock_in);
		check({msi_enable_out, msi_mmenable_out}, 4'h0);
		msi(32'h0000_0001, 1'b0, 64'h0, 32'h0, 1'b0);
		wr({8'h00, mrc_pkg::MRC_CMD_STATUS_IDX}, 32'hffff_ffff, 4'hf, 1'b0);
		rd({8'h00, mrc_pkg::MRC_CMD_STATUS_IDX}, mrc_pkg::MRC_CMD_WMASK, mrc_pkg::MRC_CMD_WMASK);
		wr({8'h00, mrc_pkg::MRC_CMD_STATUS_IDX}, 32'h0000_0000, 4'h1, 1'b0);
		rd({8'h00, mrc_pkg::MRC_CMD_STATUS_IDX}, mrc_pkg::MRC_CMD_WMASK, mrc_pkg::MRC_CMD_WMASK & 32'hffff_ff00);
		wr({8'h00, mrc_pkg::MRC_BASE_ADDRESS_ZERO_IDX}, 32'h1234_5678, 4'hf, 1'b0);
		rd({8'h00, mrc_pkg::MRC_BASE_ADDRESS_ZERO_IDX}, 32'hffff_ffff, 32'h1234_5000);
		rd({8'h01, mrc_pkg::MRC_CMD_STATUS_IDX}, 32'hffff_ffff, 32'h0000_0000);
		rd(18'h003ff, 32'hffff_ffff, 32'h0000_0000);
		rd({8'h00, mrc_pkg::MRC_TYPE1_BUS_IDX}, 32'hffff_ffff, 32'h0000_0000);
		prev = rd_data & mrc_pkg::MRC_TYPE1_RO_MASK;
		wr({8'h00, mrc_pkg::MRC_TYPE1_BUS_IDX}, ~prev, 4'hf, 1'b1);
		rd({8'h00, mrc_pkg::MRC_TYPE1_BUS_IDX}, mrc_pkg::MRC_TYPE1_RO_MASK, prev);
		wr({8'h00, mrc_pkg::MRC_MSI_ADDR_IDX}, 32'habcd_0007, 4'hf, 1'b0);
		wr({8'h00, mrc_pkg::MRC_MSI_DATA_IDX}, 32'h0000_5a00, 4'hf, 1'b0);
		wr({8'h00, mrc_pkg::MRC_MSI_CTRL_IDX}, 32'h0051_0000, 4'hf, 1'b0);
		check({msi_enable_out, msi_mmenable_out}, 4'hd);
		rd({8'h00, mrc_pkg::MRC_MSI_CTRL_IDX}, 32'h007f_0000, 32'h0057_0000);
		msi(32'h0000_001d, 1'b1, 64'habcd_0004, 32'h0000_5a05, 1'b0);
		msi(32'h0000_0002, 1'b1, 64'habcd_0004, 32'h0000_5a02, 1'b0);
		wr({8'h00, mrc_pkg::MRC_MSI_UADDR_IDX}, 32'h0000_0001, 4'hf, 1'b0);
		msi(32'h0000_0006, 1'b1, 64'h1_abcd_0004, 32'h0000_5a06, 1'b1);
		wr({8'h00, mrc_pkg::MRC_MSI_CTRL_IDX}, 32'h0001_0000, 4'hf, 1'b0);
		msi(32'h0000_0001, 1'b1, 64'h1_abcd_0004, 32'h0000_5a00, 1'b1);
		wr({8'h00, mrc_pkg::MRC_MSI_CTRL_IDX}, 32'h0000_0000, 4'hf, 1'b0);
		msi(32'h0000_0001, 1'b0, 64'h0, 32'h0, 1'b0);
		results();
	end
endmodule

/* verilog/mrc_msi_cfg.sv */
/*
 * Message interrupt request logic and configuration management port.
 * Assumes the user holds requests stable until acceptance and that the
 * transmit path consumes the one-cycle descriptor strobe.
 */
`timescale 1ns/1ps
module mrc_msi_cfg #(
	parameter logic [2:0] MSG_CAPABLE = 3'h5,
	parameter logic ROOT_PORT = 1'b0,
	parameter int FUNC_COUNT = 1
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic [31:0] msi_int_in,
	input wire mrc_pkg::mrc_mgmt_req_t mgmt_in,
	output logic msi_sent_out,
	output logic msi_enable_out,
	output logic [2:0] msi_mmenable_out,
	output logic msi_tlp_valid_out,
	output mrc_pkg::mrc_msi_tlp_t msi_tlp_out,
	output logic [31:0] mgmt_read_data_out,
	output logic mgmt_done_out
);
	////////////////////////////////////////////////////////////////////////
	logic [31:0] cmd_q;
	logic [31:0] base_address_zero_q;
	logic [31:0] ctrl_q;
	logic [31:0] maddr_q;
	logic [31:0] uaddr_q;
	logic [31:0] mdata_q;
	logic [31:0] bus_q;
	logic busy_q;
	logic [1:0] cnt_q;
	mrc_pkg::mrc_mgmt_state_t st_q;
	logic [2:0] mme;
	logic [2:0] eff;
	logic [31:0] merged;
	logic [31:0] lowmask;
	logic hit_func;

	// Merges write data into a register under byte and field masks.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] wm);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~(bm & wm)) | (wd & bm & wm);
	endfunction

	// Host-programmed enable, and the effective vector count.
	assign mme = ctrl_q[mrc_pkg::MRC_MME_LSB +: 3];
	assign eff = (mme < MSG_CAPABLE) ? mme : MSG_CAPABLE;
	assign lowmask = ~(32'hffff_ffff << eff);
	assign merged = (mdata_q & ~lowmask) | (msi_int_in & lowmask);
	assign hit_func = (int'(mgmt_in.addr[17:10]) < FUNC_COUNT);

	////////////////////////////////////////////////////////////////////////
	// Management port sequencing: read answers next cycle, write after a latency.
	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
		begin
			st_q <= mrc_pkg::MRC_IDLE;
			cnt_q <= 2'h0;
			mgmt_done_out <= 1'b0;
			mgmt_read_data_out <= mrc_pkg::MRC_ZERO;
		end
		else
		begin
			mgmt_done_out <= 1'b0;
			unique case (st_q)
				mrc_pkg::MRC_IDLE:
				begin
					if (mgmt_in.wr)
					begin
						st_q <= mrc_pkg::MRC_WRITE;
						cnt_q <= mrc_pkg::MRC_WR_LAT;
					end
					else if (mgmt_in.rd)
					begin
						mgmt_done_out <= 1'b1;
						st_q <= mrc_pkg::MRC_DONE;
						if (!hit_func)
							mgmt_read_data_out <= mrc_pkg::MRC_ZERO;
						else
							unique case (mgmt_in.addr[9:0])
								mrc_pkg::MRC_CMD_STATUS_IDX: mgmt_read_data_out <= cmd_q;
								mrc_pkg::MRC_BASE_ADDRESS_ZERO_IDX: mgmt_read_data_out <= base_address_zero_q;
								mrc_pkg::MRC_MSI_CTRL_IDX: mgmt_read_data_out <= ctrl_q |
									(32'(MSG_CAPABLE) << mrc_pkg::MRC_MMC_LSB);
								mrc_pkg::MRC_MSI_ADDR_IDX: mgmt_read_data_out <= maddr_q;
								mrc_pkg::MRC_MSI_UADDR_IDX: mgmt_read_data_out <= uaddr_q;
								mrc_pkg::MRC_MSI_DATA_IDX: mgmt_read_data_out <= mdata_q;
								mrc_pkg::MRC_TYPE1_BUS_IDX: mgmt_read_data_out <= bus_q;
								default: mgmt_read_data_out <= mrc_pkg::MRC_ZERO;
							endcase
					end
				end
				mrc_pkg::MRC_WRITE:
				begin
					cnt_q <= cnt_q - 2'h1;
					if (cnt_q == 2'h1)
					begin
						mgmt_done_out <= 1'b1;
						st_q <= mrc_pkg::MRC_DONE;
					end
				end
				mrc_pkg::MRC_DONE:
					st_q <= mrc_pkg::MRC_IDLE; // Strobe is dropped here by the user.
				default: st_q <= mrc_pkg::MRC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register updates, committed in the cycle done is raised for a write.
	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
		begin
			cmd_q <= mrc_pkg::MRC_ZERO;
			base_address_zero_q <= mrc_pkg::MRC_ZERO;
			ctrl_q <= mrc_pkg::MRC_ZERO;
			maddr_q <= mrc_pkg::MRC_ZERO;
			uaddr_q <= mrc_pkg::MRC_ZERO;
			mdata_q <= mrc_pkg::MRC_ZERO;
			bus_q <= mrc_pkg::MRC_ZERO;
		end
		else if (st_q == mrc_pkg::MRC_WRITE && cnt_q == 2'h1 && hit_func)
		begin
			unique case (mgmt_in.addr[9:0])
				mrc_pkg::MRC_CMD_STATUS_IDX: cmd_q <= merge(cmd_q, mgmt_in.wdata, mgmt_in.be,
					mrc_pkg::MRC_CMD_WMASK);
				mrc_pkg::MRC_BASE_ADDRESS_ZERO_IDX: base_address_zero_q <= merge(base_address_zero_q, mgmt_in.wdata, mgmt_in.be,
					mrc_pkg::MRC_BASE_ADDRESS_ZERO_WMASK);
				mrc_pkg::MRC_MSI_CTRL_IDX: ctrl_q <= merge(ctrl_q, mgmt_in.wdata, mgmt_in.be,
					mrc_pkg::MRC_CTRL_WMASK);
				mrc_pkg::MRC_MSI_ADDR_IDX: maddr_q <= merge(maddr_q, mgmt_in.wdata, mgmt_in.be,
					mrc_pkg::MRC_ADDR_WMASK);
				mrc_pkg::MRC_MSI_UADDR_IDX: uaddr_q <= merge(uaddr_q, mgmt_in.wdata, mgmt_in.be,
					~mrc_pkg::MRC_ZERO);
				mrc_pkg::MRC_MSI_DATA_IDX: mdata_q <= merge(mdata_q, mgmt_in.wdata, mgmt_in.be,
					~mrc_pkg::MRC_ZERO);
				mrc_pkg::MRC_TYPE1_BUS_IDX: bus_q <= merge(bus_q, mgmt_in.wdata, mgmt_in.be,
					(ROOT_PORT && mgmt_in.type1_override) ? ~mrc_pkg::MRC_ZERO
					: ~mrc_pkg::MRC_TYPE1_RO_MASK);
				default: cmd_q <= cmd_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Message request: accept once per nonzero request, then emit one write.
	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
		begin
			busy_q <= 1'b0;
			msi_sent_out <= 1'b0;
			msi_tlp_valid_out <= 1'b0;
			msi_tlp_out <= '0;
		end
		else
		begin
			msi_sent_out <= 1'b0;
			msi_tlp_valid_out <= msi_sent_out;
			if (msi_int_in == mrc_pkg::MRC_ZERO)
				busy_q <= 1'b0;
			if (!busy_q && msi_int_in != mrc_pkg::MRC_ZERO && ctrl_q[mrc_pkg::MRC_MSI_EN_BIT])
			begin
				busy_q <= 1'b1;
				msi_sent_out <= 1'b1;
				msi_tlp_out.addr <= {uaddr_q, maddr_q};
				msi_tlp_out.data <= merged;
				msi_tlp_out.is_64 <= (uaddr_q != mrc_pkg::MRC_ZERO);
			end
		end
	end

	// Status outputs mirror the capability control word.
	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
		begin
			msi_enable_out <= 1'b0;
			msi_mmenable_out <= 3'h0;
		end
		else
		begin
			msi_enable_out <= ctrl_q[mrc_pkg::MRC_MSI_EN_BIT];
			msi_mmenable_out <= mme;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_sent_then_tlp;
		@(posedge clock_in) disable iff (!reset_n_in) msi_sent_out |=> msi_tlp_valid_out;
	endproperty
	a_sent_then_tlp: assert property (p_sent_then_tlp) else $error("No write after accept.");
	property p_width;
		@(posedge clock_in) disable iff (!reset_n_in)
			msi_tlp_valid_out |-> (msi_tlp_out.is_64 == (msi_tlp_out.addr[63:32] != 32'h0));
	endproperty
	a_width: assert property (p_width) else $error("Address width mismatch.");
	property p_enable;
		@(posedge clock_in) disable iff (!reset_n_in) msi_sent_out |-> $past(ctrl_q[mrc_pkg::MRC_MSI_EN_BIT]);
	endproperty
	a_enable: assert property (p_enable) else $error("Message sent while disabled.");
	// Uncovered bits come from the message data, covered bits from the request.
	property p_mask;
		@(posedge clock_in) disable iff (!reset_n_in)
			msi_sent_out |-> ((((msi_tlp_out.data ^ $past(mdata_q)) & ~$past(lowmask)) == 32'h0) &&
				(((msi_tlp_out.data ^ $past(msi_int_in)) & $past(lowmask)) == 32'h0));
	endproperty
	a_mask: assert property (p_mask) else $error("Uncovered select bit kept.");
	property p_one_done;
		@(posedge clock_in) disable iff (!reset_n_in) mgmt_done_out |=> !mgmt_done_out;
	endproperty
	a_one_done: assert property (p_one_done) else $error("Done longer than one cycle.");
	sequence s_write_start;
		st_q == mrc_pkg::MRC_IDLE && mgmt_in.wr;
	endsequence
	property p_write_done;
		@(posedge clock_in) disable iff (!reset_n_in) s_write_start |-> ##3 mgmt_done_out;
	endproperty
	a_write_done: assert property (p_write_done) else $error("Write done late.");
	property p_read_done;
		@(posedge clock_in) disable iff (!reset_n_in)
			(st_q == mrc_pkg::MRC_IDLE && !mgmt_in.wr && mgmt_in.rd) |=> mgmt_done_out;
	endproperty
	a_read_done: assert property (p_read_done) else $error("Read done missing.");
	property p_mme_cap;
		@(posedge clock_in) disable iff (!reset_n_in) eff <= MSG_CAPABLE && eff <= mme;
	endproperty
	a_mme_cap: assert property (p_mme_cap) else $error("Vector count exceeds limit.");
endmodule

/* verilog/mrc_pkg.sv */
/*
 * Constants and carrier types for the interrupt request and configuration port block.
 * Assumes a single user clock and a synchronous active-low reset.
 */
package mrc_pkg;
	// Dword index and byte offset of the command/status word.
	localparam logic [9:0] MRC_CMD_STATUS_IDX = 10'h001;
	localparam logic [7:0] MRC_CMD_STATUS_OFS = 8'h04;
	// Dword index and byte offset of base address zero.
	localparam logic [9:0] MRC_BASE_ADDRESS_ZERO_IDX = 10'h004;
	localparam logic [7:0] MRC_BASE_ADDRESS_ZERO_OFS = 8'h10;
	// Dword indices of the message capability words.
	localparam logic [9:0] MRC_MSI_CTRL_IDX = 10'h014;
	localparam logic [9:0] MRC_MSI_ADDR_IDX = 10'h015;
	localparam logic [9:0] MRC_MSI_UADDR_IDX = 10'h016;
	localparam logic [9:0] MRC_MSI_DATA_IDX = 10'h017;
	// Dword index of a bridge-only header word (secondary latency/bus numbers).
	localparam logic [9:0] MRC_TYPE1_BUS_IDX = 10'h006;
	// Field positions inside the message control word.
	localparam int MRC_MSI_EN_BIT = 16;
	localparam int MRC_MME_LSB = 20;
	localparam int MRC_MMC_LSB = 17;
	// Writable masks, the bridge read-only mask, and zero.
	localparam logic [31:0] MRC_CMD_WMASK = 32'h0000_0547;
	localparam logic [31:0] MRC_BASE_ADDRESS_ZERO_WMASK = 32'hffff_f000;
	localparam logic [31:0] MRC_CTRL_WMASK = 32'h0071_0000;
	localparam logic [31:0] MRC_ADDR_WMASK = 32'hffff_fffc;
	localparam logic [31:0] MRC_TYPE1_RO_MASK = 32'hff00_0000;
	localparam logic [31:0] MRC_ZERO = 32'h0000_0000;
	// Write counter load; done follows the write strobe by one cycle more than this.
	localparam logic [1:0] MRC_WR_LAT = 2'h2;

	// Management request carried as one packed group.
	typedef struct packed {
		logic [17:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
		logic wr;
		logic rd;
		logic type1_override;
	} mrc_mgmt_req_t;

	// Outgoing message write descriptor.
	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] data;
		logic is_64;
	} mrc_msi_tlp_t;

	typedef enum logic [1:0] {
		MRC_IDLE = 2'b00,
		MRC_WRITE = 2'b01,
		MRC_DONE = 2'b10
	} mrc_mgmt_state_t;
endpackage
